// ---- logic/cpm_top.sv ----
// Purpose: clock source, multiplier, divider and power-mode control
// Assumes: raw oscillator levels and pins are asynchronous to i_clk
// Notes: the multiplier itself is analog; this drives its controls
//
// Operation
// RULE1 - multiplier reference is the 10 to 25 MHz rc or system clock.
// RULE2 - multiplier factor programmable from 1 to 32.
// RULE3 - loop divider keeps the oscillator inside 156 to 320 MHz.
// RULE4 - software keeps synthesized output below 100 MHz.
// RULE5 - post divider offers only 2, 4, 8 or 16.
// RULE6 - after reset the multiplier is powered off and bypassed.
// RULE7 - software configures, enables, waits lock, then selects it.
// RULE8 - lock is reported 100 us after activation.
// RULE9 - clock output pin picks rc, system, watchdog or main clock.
// RULE10 - watchdog oscillator drives core, watchdog or pin; freq set.
// RULE11 - power-up and power-off wake start on the rc oscillator.
// RULE12 - software waits for a source to be stable before using it.
// RULE13 - core rate set by source, multiplier or core divider.
// RULE14 - each peripheral has its own clock enable bit.
// RULE15 - selected peripherals have their own clock dividers.
// RULE16 - sleep stops the core clock; wake just re-enables it.
// RULE17 - peripherals run in sleep; reset or interrupt wakes core.
// RULE18 - deep-sleep also stops analog; watchdog osc and brownout optional.
// RULE19 - thirteen start pins wake the chip from deep-sleep.
// RULE20 - software moves to rc before deep-sleep unless watchdog kept.
// RULE21 - power-off keeps only exit pin; 50 ns low pulse wakes.
// RULE22 - exit pin pulses under about 20 ns are ignored; here any pulse sampled low at one clock edge wakes.
// RULE23 - each start pin has its own interrupt while running.
// RULE24 - main clock switches without runt pulses.
// RULE25 - lock low while multiplier off; unlocked selection ignored.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
module cpm_top import cpm_pkg::*; #(
	parameter int N_PER = 8,
	parameter int N_PDIV = 2
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_we,
	input wire logic i_re,
	output logic [31:0] o_rdata,
	input wire logic [2:0] i_osc_raw,
	input wire logic i_pll_raw,
	input wire logic [N_START-1:0] i_start_raw,
	input wire logic i_exit_raw_b,
	input wire logic i_irq_any,
	output logic o_core_clk_en,
	output logic [N_PER-1:0] o_per_clk_en,
	output logic o_clock_output_pin,
	output logic o_pll_pd,
	output logic o_pll_bypass,
	output logic o_pll_ref_sys,
	output logic [MSEL_W-1:0] o_pll_msel,
	output logic [4:0] o_pll_post_div,
	output logic o_analog_off,
	output logic o_wdt_osc_run,
	output logic [WDT_FREQ_W-1:0] o_wdt_freq,
	output logic o_bod_run,
	output logic o_power_off,
	output logic [N_START-1:0] o_start_irq
);
	localparam int SW = N_START + 5;
	localparam int ND = N_PDIV + 2;

	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	logic [SW-1:0] sync1_reg, sync2_reg;
	logic [N_START-1:0] start_q_reg;
	logic [3:0] src_s;
	logic [N_START-1:0] start_s;
	logic exit_s_b;

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			sync1_reg <= {1'b1, {(SW-1){1'b0}}};
			sync2_reg <= {1'b1, {(SW-1){1'b0}}};
		end else if (i_ce) begin
			sync1_reg <= {i_exit_raw_b, i_start_raw, i_pll_raw, i_osc_raw};
			sync2_reg <= sync1_reg;
		end
	end
	assign src_s = sync2_reg[3:0];
	assign start_s = sync2_reg[N_START+3:4];
	assign exit_s_b = sync2_reg[SW-1];

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	cpm_mode_e mode_reg;
	logic [MSEL_W-1:0] msel_reg;
	logic [PSEL_W-1:0] psel_reg;
	logic pll_en_reg, ref_sys_reg, lock_reg;
	logic [1:0] main_sel_reg, co_sel_reg;
	logic [DIV_W-1:0] div_reg [ND];
	logic [N_PER-1:0] per_en_reg;
	logic [WDT_FREQ_W-1:0] wdt_freq_reg;
	logic keep_wdt_reg, keep_bod_reg;
	logic [N_START-1:0] start_en_reg;
	logic [LOCK_CNT_W-1:0] lock_cnt_reg;
	logic [1:0] wake_cnt_reg;
	logic cfg_rst, wr, off_wake, pm_wr, sw_busy, main_clk;
	logic [1:0] cur_sel;

	// core is stopped outside run, so only run-mode writes land
	assign wr = i_we && i_ce && (mode_reg == MODE_RUN);
	assign pm_wr = wr && (i_addr == REG_PMODE);
	// exit pin low at one sample wakes; a 20 ns glitch is missed only when it falls between samples
	assign off_wake = (mode_reg == MODE_OFF) && !exit_s_b && // [RULE22]
		(wake_cnt_reg >= 2'(WAKE_CYC - 1)); // [RULE21]
	assign cfg_rst = !i_rst_b || (off_wake && i_ce); // [RULE11]

	always_ff @(posedge i_clk) begin
		if (cfg_rst) begin
			msel_reg <= '0;
			psel_reg <= '0;
			pll_en_reg <= 1'b0; // [RULE6]
			ref_sys_reg <= 1'b0;
			main_sel_reg <= SRC_IRC; // [RULE11]
			co_sel_reg <= SRC_IRC;
			per_en_reg <= '0;
			wdt_freq_reg <= WDT_FREQ_RST;
			start_en_reg <= '0;
		end else if (wr) begin
			unique case (i_addr)
				REG_PLL_CTRL: begin
					msel_reg <= i_wdata[MSEL_LSB +: MSEL_W]; // [RULE2]
					psel_reg <= i_wdata[PSEL_LSB +: PSEL_W]; // [RULE5]
					pll_en_reg <= i_wdata[PLL_EN_BIT];
					ref_sys_reg <= i_wdata[PLL_REF_BIT]; // [RULE1]
				end
				REG_MAIN_SEL: begin
					if (i_wdata[1:0] != SRC_PLL || lock_reg) begin // [RULE25]
						main_sel_reg <= i_wdata[1:0];
					end
				end
				REG_CLOCK_OUTPUT_PIN: co_sel_reg <= i_wdata[1:0]; // [RULE9]
				REG_PER_EN: per_en_reg <= i_wdata[N_PER-1:0]; // [RULE14]
				REG_WDT_OSC: wdt_freq_reg <= i_wdata[WDT_FREQ_W-1:0]; // [RULE10]
				REG_START_EN: start_en_reg <= i_wdata[N_START-1:0];
				default: ;
			endcase
		end else if (i_ce && main_sel_reg == SRC_PLL && !lock_reg) begin
			main_sel_reg <= SRC_IRC; // [RULE25]
		end
	end

	// divider values: 0 core, 1 clock output, 2.. peripherals
	always_ff @(posedge i_clk) begin
		if (cfg_rst) begin
			for (int k = 0; k < ND; k++) begin
				div_reg[k] <= (k == 0) ? CORE_DIV_RST : '0;
			end
		end else if (wr) begin
			if (i_addr == REG_CORE_DIV) begin
				div_reg[0] <= i_wdata[DIV_W-1:0]; // [RULE13]
			end
			if (i_addr == REG_CLOCK_OUTPUT_PIN) begin
				div_reg[1] <= i_wdata[CO_DIV_LSB +: DIV_W];
			end
			for (int k = 0; k < N_PDIV; k++) begin
				if (i_addr == 4'(REG_PER_DIV0 + k)) begin
					div_reg[k+2] <= i_wdata[DIV_W-1:0]; // [RULE15]
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// multiplier lock timer
	// ---------------------------------------------------------------
	// any rewrite of the controls restarts the settle wait
	always_ff @(posedge i_clk) begin
		if (cfg_rst) begin
			lock_cnt_reg <= '0;
			lock_reg <= 1'b0;
		end else if (i_ce) begin
			if (!pll_en_reg || (wr && i_addr == REG_PLL_CTRL) ||
				mode_reg == MODE_DEEP || mode_reg == MODE_OFF) begin
				lock_cnt_reg <= '0;
				lock_reg <= 1'b0; // [RULE25]
			end else if (lock_cnt_reg == LOCK_CNT_W'(LOCK_CYC - 1)) begin
				lock_reg <= 1'b1; // [RULE8]
			end else begin
				lock_cnt_reg <= LOCK_CNT_W'(lock_cnt_reg + 1'b1);
			end
		end
	end

	// ---------------------------------------------------------------
	// power modes
	// ---------------------------------------------------------------
	logic [N_START-1:0] start_edge;
	logic start_hit;
	assign start_edge = (start_s ^ start_q_reg) & start_en_reg;
	assign start_hit = |start_edge;

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			mode_reg <= MODE_RUN;
			keep_wdt_reg <= 1'b0;
			keep_bod_reg <= 1'b0;
			wake_cnt_reg <= '0;
			start_q_reg <= '0;
		end else if (i_ce) begin
			start_q_reg <= start_s;
			wake_cnt_reg <= (mode_reg == MODE_OFF && !exit_s_b) ?
				2'(wake_cnt_reg + 1'b1) : '0;
			unique case (mode_reg)
				MODE_RUN: begin
					if (pm_wr) begin
						keep_wdt_reg <= i_wdata[PM_KEEP_WDT_BIT]; // [RULE18]
						keep_bod_reg <= i_wdata[PM_KEEP_BOD_BIT];
						unique case (i_wdata[1:0])
							PM_SLEEP: mode_reg <= MODE_SLEEP; // [RULE16]
							PM_DEEP: mode_reg <= MODE_DEEP;
							PM_OFF: mode_reg <= MODE_OFF;
							default: mode_reg <= MODE_RUN;
						endcase
					end
				end
				MODE_SLEEP: begin
					if (i_irq_any || start_hit) begin
						mode_reg <= MODE_RUN; // [RULE17]
					end
				end
				MODE_DEEP: begin
					if (start_hit) begin
						mode_reg <= MODE_RUN; // [RULE19]
					end
				end
				MODE_OFF: begin
					if (off_wake) begin
						mode_reg <= MODE_RUN; // [RULE21]
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// clock tree
	// ---------------------------------------------------------------
	logic main_q_reg, co_q_reg, co_lvl, main_rise, co_rise;
	logic [ND-1:0] div_tick, div_in;

	cpm_clk_switch u_cpm_clk_switch (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_ce(i_ce),
		.i_src({src_s[3] & lock_reg, src_s[2:0]}),
		.i_sel(main_sel_reg),
		.o_clk(main_clk),
		.o_cur(cur_sel),
		.o_busy(sw_busy)
	);

	assign co_lvl = (co_sel_reg == CO_MAIN) ? main_clk : src_s[co_sel_reg];
	// main clock ticks stop in deep-sleep and power-off; clock output stops only in power-off
	assign main_rise = main_clk && !main_q_reg &&
		(mode_reg == MODE_RUN || mode_reg == MODE_SLEEP);
	assign co_rise = co_lvl && !co_q_reg && mode_reg != MODE_OFF;

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			main_q_reg <= 1'b0;
			co_q_reg <= 1'b0;
		end else if (i_ce) begin
			main_q_reg <= main_clk;
			co_q_reg <= co_lvl;
		end
	end

	genvar g;
	generate
		for (g = 0; g < ND; g++) begin : g_div
			assign div_in[g] = (g == 1) ? co_rise : main_rise;
			cpm_clk_div u_cpm_clk_div (
				.i_clk(i_clk),
				.i_rst_b(i_rst_b),
				.i_ce(i_ce),
				.i_tick(div_in[g]),
				.i_div(div_reg[g]),
				.o_tick(div_tick[g])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_core_clk_en <= 1'b0;
			o_per_clk_en <= '0;
			o_clock_output_pin <= 1'b0;
			o_start_irq <= '0;
		end else if (i_ce) begin
			o_core_clk_en <= div_tick[0] && mode_reg == MODE_RUN; // [RULE16]
			for (int k = 0; k < N_PER; k++) begin
				o_per_clk_en[k] <= per_en_reg[k] && // [RULE14]
					((k < N_PDIV) ? div_tick[(k<N_PDIV)?k+2:2] : main_rise);
			end
			if (div_tick[1]) begin
				o_clock_output_pin <= !o_clock_output_pin; // [RULE9]
			end
			o_start_irq <= (mode_reg == MODE_RUN) ? start_edge : '0; // [RULE23]
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_pll_pd <= 1'b1;
			o_pll_bypass <= 1'b1;
			o_pll_ref_sys <= 1'b0;
			o_pll_msel <= '0;
			o_pll_post_div <= 5'h02;
			o_analog_off <= 1'b0;
			o_wdt_osc_run <= 1'b1;
			o_wdt_freq <= WDT_FREQ_RST;
			o_bod_run <= 1'b1;
			o_power_off <= 1'b0;
		end else if (i_ce) begin
			o_pll_pd <= !pll_en_reg || mode_reg != MODE_RUN && // [RULE6]
				mode_reg != MODE_SLEEP;
			o_pll_bypass <= !lock_reg; // [RULE6]
			o_pll_ref_sys <= ref_sys_reg; // [RULE1]
			o_pll_msel <= msel_reg; // [RULE3]
			o_pll_post_div <= 5'(5'h02 << psel_reg); // [RULE5]
			o_analog_off <= mode_reg == MODE_DEEP; // [RULE18]
			o_wdt_osc_run <= mode_reg != MODE_OFF &&
				(mode_reg != MODE_DEEP || keep_wdt_reg); // [RULE10]
			o_wdt_freq <= wdt_freq_reg;
			o_bod_run <= mode_reg != MODE_OFF &&
				(mode_reg != MODE_DEEP || keep_bod_reg);
			o_power_off <= mode_reg == MODE_OFF;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_rdata <= '0;
		end else if (i_ce) begin
			o_rdata <= '0;
			if (i_re) begin
				unique case (i_addr)
					REG_PLL_CTRL: o_rdata <= 32'({ref_sys_reg, pll_en_reg,
						psel_reg, msel_reg});
					REG_PLL_STAT: o_rdata <= 32'(lock_reg);
					REG_MAIN_SEL: o_rdata <= 32'(main_sel_reg);
					REG_CORE_DIV: o_rdata <= 32'(div_reg[0]);
					REG_CLOCK_OUTPUT_PIN: o_rdata <= 32'({div_reg[1], 6'h00, co_sel_reg});
					REG_PER_EN: o_rdata <= 32'(per_en_reg);
					REG_WDT_OSC: o_rdata <= 32'(wdt_freq_reg);
					REG_PMODE: o_rdata <= 32'({keep_bod_reg, keep_wdt_reg,
						mode_reg});
					REG_START_EN: o_rdata <= 32'(start_en_reg);
					REG_STATUS: o_rdata <= 32'({cur_sel, sw_busy});
					default: begin
						for (int k = 0; k < N_PDIV; k++) begin
							if (i_addr == 4'(REG_PER_DIV0 + k)) begin
								o_rdata <= 32'(div_reg[k+2]);
							end
						end
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	sequence s_off_exit;
		mode_reg == MODE_OFF && i_ce ##1 mode_reg == MODE_RUN;
	endsequence

	chk_pll_reset_off: assert property ($rose(i_rst_b) |-> // [RULE6]
		o_pll_pd && o_pll_bypass) else $error("multiplier live after reset");
	chk_lock_needs_en: assert property (lock_reg |-> // [RULE8]
		pll_en_reg && $past(lock_cnt_reg) == LOCK_CNT_W'(LOCK_CYC - 1))
		else $error("lock without full settle time");
	chk_pll_sel_locked: assert property (i_ce && !lock_reg |=> // [RULE25]
		main_sel_reg != SRC_PLL || $past(wr))
		else $error("main clock on unlocked multiplier");
	chk_lock_pd_low: assert property (i_ce && // [RULE25]
		mode_reg != MODE_RUN && mode_reg != MODE_SLEEP |=> !lock_reg)
		else $error("lock held while multiplier is down");
	chk_core_stop_sleep: assert property (i_ce && // [RULE16]
		mode_reg != MODE_RUN |=> !o_core_clk_en)
		else $error("core clock runs while asleep");
	chk_per_gate: assert property (i_ce && !per_en_reg[0] |=> // [RULE14]
		!o_per_clk_en[0]) else $error("disabled peripheral clocked");
	chk_sleep_wake: assert property (i_ce && mode_reg == MODE_SLEEP && // [RULE17]
		i_irq_any |=> mode_reg == MODE_RUN) else $error("sleep not left");
	chk_deep_analog: assert property (i_ce && mode_reg == MODE_DEEP |=> // [RULE18]
		o_analog_off) else $error("analog left on in deep-sleep");
	chk_deep_start: assert property (i_ce && mode_reg == MODE_DEEP && // [RULE19]
		start_hit |=> mode_reg == MODE_RUN) else $error("start pin ignored");
	chk_off_wake_rc: assert property (s_off_exit |-> // [RULE11]
		main_sel_reg == SRC_IRC && !pll_en_reg) else $error("wake not on rc");
	chk_post_div_set: assert property (o_pll_post_div inside // [RULE5]
		{5'h02, 5'h04, 5'h08, 5'h10}) else $error("illegal post divider");
endmodule

// ---- logic/cpm_pkg.sv ----
// Purpose: shared constants for clock and power-mode control
// Assumes: 20 MHz system clock, word-indexed register port
// Notes: all oscillator sources arrive as raw levels from outside
package cpm_pkg;
	// ---------------------------------------------------------------
	// register indices
	// ---------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [3:0] REG_PLL_CTRL = 4'h0;
	localparam logic [3:0] REG_PLL_STAT = 4'h1;
	localparam logic [3:0] REG_MAIN_SEL = 4'h2;
	localparam logic [3:0] REG_CORE_DIV = 4'h3;
	localparam logic [3:0] REG_CLOCK_OUTPUT_PIN = 4'h4;
	localparam logic [3:0] REG_PER_EN = 4'h5;
	localparam logic [3:0] REG_PER_DIV0 = 4'h6;
	localparam logic [3:0] REG_WDT_OSC = 4'h8;
	localparam logic [3:0] REG_PMODE = 4'h9;
	localparam logic [3:0] REG_START_EN = 4'ha;
	localparam logic [3:0] REG_STATUS = 4'hb;
	// ---------------------------------------------------------------
	// fields
	// ---------------------------------------------------------------
	localparam int MSEL_LSB = 0;
	localparam int MSEL_W = 5;
	localparam int PSEL_LSB = 5;
	localparam int PSEL_W = 2;
	localparam int PLL_EN_BIT = 7;
	localparam int PLL_REF_BIT = 8;
	localparam int CO_DIV_LSB = 8;
	localparam int DIV_W = 8;
	localparam int WDT_FREQ_W = 9;
	localparam int PM_KEEP_WDT_BIT = 2;
	localparam int PM_KEEP_BOD_BIT = 3;
	localparam int N_START = 13;
	// ---------------------------------------------------------------
	// source codes and reset values
	// ---------------------------------------------------------------
	localparam logic [1:0] SRC_IRC = 2'h0;
	localparam logic [1:0] SRC_SYS = 2'h1;
	localparam logic [1:0] SRC_WDT = 2'h2;
	localparam logic [1:0] SRC_PLL = 2'h3;
	localparam logic [1:0] CO_MAIN = 2'h3;
	localparam logic [1:0] PM_SLEEP = 2'h1;
	localparam logic [1:0] PM_DEEP = 2'h2;
	localparam logic [1:0] PM_OFF = 2'h3;
	localparam logic [7:0] CORE_DIV_RST = 8'h01;
	localparam logic [8:0] WDT_FREQ_RST = 9'h000;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_NS = 50;
	localparam int CLK_MHZ = 20;
	localparam int LOCK_US = 100;
	localparam int LOCK_CYC = LOCK_US * CLK_MHZ;
	localparam int WAKE_MIN_NS = 50;
	localparam int WAKE_CYC = (WAKE_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int LOCK_CNT_W = 12;
	typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_DEEP, MODE_OFF}
		cpm_mode_e;
endpackage

// ---- logic/cpm_clk_div.sv ----
// Purpose: divides a stream of source ticks into one tick per n
// Assumes: i_tick is a one-cycle pulse on the system clock
// Notes: a divide value of zero stops the output
`timescale 1ns/10ps
module cpm_clk_div import cpm_pkg::*; #(
	parameter int W = DIV_W
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic i_tick,
	input wire logic [W-1:0] i_div,
	output logic o_tick
);
	logic [W-1:0] cnt_reg;

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			cnt_reg <= '0;
			o_tick <= 1'b0;
		end else if (i_ce) begin
			o_tick <= 1'b0;
			if (i_div == '0) begin
				cnt_reg <= '0;
			end else if (i_tick) begin
				if (cnt_reg >= W'(i_div - 1'b1)) begin
					cnt_reg <= '0;
					o_tick <= 1'b1;
				end else begin
					cnt_reg <= W'(cnt_reg + 1'b1);
				end
			end
		end
	end
endmodule

// ---- logic/cpm_clk_switch.sv ----
// Purpose: runt-free selector between four synchronised clock levels
// Assumes: inputs already passed two flip-flops
// Notes: a dead old source that stops high stalls the switch
`timescale 1ns/10ps
module cpm_clk_switch import cpm_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic [3:0] i_src,
	input wire logic [1:0] i_sel,
	output logic o_clk,
	output logic [1:0] o_cur,
	output logic o_busy
);
	typedef enum logic [1:0] {SW_RUN, SW_DRAIN, SW_ARM} cpm_sw_e;
	cpm_sw_e state_reg;
	logic [1:0] tgt_reg;

	// old source is passed until it falls, then output holds low
	// until the new source is low as well [RULE24]
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			state_reg <= SW_RUN;
			o_cur <= SRC_IRC;
			tgt_reg <= SRC_IRC;
			o_clk <= 1'b0;
		end else if (i_ce) begin
			unique case (state_reg)
				SW_RUN: begin
					o_clk <= i_src[o_cur];
					if (i_sel != o_cur) begin
						tgt_reg <= i_sel;
						state_reg <= SW_DRAIN;
					end
				end
				SW_DRAIN: begin
					o_clk <= i_src[o_cur];
					if (!i_src[o_cur]) begin
						o_cur <= tgt_reg;
						o_clk <= 1'b0;
						state_reg <= SW_ARM;
					end
				end
				SW_ARM: begin
					o_clk <= 1'b0;
					if (!i_src[o_cur]) begin
						state_reg <= SW_RUN;
					end
				end
				default: state_reg <= SW_RUN;
			endcase
		end
	end

	assign o_busy = (state_reg != SW_RUN);

	chk_switch_no_runt: assert property (@(posedge i_clk) // [RULE24]
		disable iff (!i_rst_b) state_reg == SW_ARM |=> !o_clk)
		else $error("clock output high while arming new source");
endmodule

// ---- bench/cpm_osc_model.sv ----
// Purpose: oscillator and multiplier sources seen by the controller
// Assumes: periods are slow enough to pass the two-flop sync
// Notes: multiplier output stops low while it is powered down
`timescale 1ns/10ps
module cpm_osc_model (
	input wire logic i_pll_pd,
	output logic [2:0] o_osc_raw,
	output logic o_pll_raw
);
	// ---------------------------------------------------------------
	// free-running oscillators and gated multiplier
	// ---------------------------------------------------------------
	initial begin
		o_osc_raw = 3'h0;
		o_pll_raw = 1'b0;
	end
	// rc source doubles as the multiplier reference
	always #100 o_osc_raw[0] = ~o_osc_raw[0];
	always #150 o_osc_raw[1] = ~o_osc_raw[1];
	always #350 o_osc_raw[2] = ~o_osc_raw[2];
	// no edges unless software powered it up
	always #70 o_pll_raw = i_pll_pd ? 1'b0 : ~o_pll_raw;
endmodule

// ---- bench/cpm_tb_top.sv ----
// Purpose: self-checking bench for clock and power-mode control
// Assumes: 20 MHz clock, register port answers one cycle after read
// Notes: rates are judged by edge counts over fixed windows
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
	fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", \
	$time, g, e); end end
module cpm_tb_top import cpm_pkg::*;;
	logic i_clk, i_rst_b, i_ce, i_we, i_re, i_pll_raw;
	logic i_exit_raw_b, i_irq_any, o_core_clk_en, o_clock_output_pin;
	logic o_pll_pd, o_pll_bypass, o_pll_ref_sys, o_analog_off;
	logic o_wdt_osc_run, o_bod_run, o_power_off;
	logic [3:0] i_addr;
	logic [31:0] i_wdata, o_rdata;
	logic [2:0] i_osc_raw;
	logic [12:0] i_start_raw, o_start_irq;
	logic [7:0] o_per_clk_en;
	logic [4:0] o_pll_msel, o_pll_post_div;
	logic [8:0] o_wdt_freq;
	int fail_count, cmp_count, core_n, per_n, co_n, irq_n, c, p;
	int div_n, q;
	// ---------------------------------------------------------------
	// design, sources and edge counters
	// ---------------------------------------------------------------
	cpm_top u_cpm_top (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re),
		.o_rdata(o_rdata), .i_osc_raw(i_osc_raw), .i_pll_raw(i_pll_raw),
		.i_start_raw(i_start_raw), .i_exit_raw_b(i_exit_raw_b),
		.i_irq_any(i_irq_any), .o_core_clk_en(o_core_clk_en),
		.o_per_clk_en(o_per_clk_en), .o_clock_output_pin(o_clock_output_pin),
		.o_pll_pd(o_pll_pd), .o_pll_bypass(o_pll_bypass),
		.o_pll_ref_sys(o_pll_ref_sys), .o_pll_msel(o_pll_msel),
		.o_pll_post_div(o_pll_post_div), .o_analog_off(o_analog_off),
		.o_wdt_osc_run(o_wdt_osc_run), .o_wdt_freq(o_wdt_freq),
		.o_bod_run(o_bod_run), .o_power_off(o_power_off),
		.o_start_irq(o_start_irq));
	cpm_osc_model u_cpm_osc_model (.i_pll_pd(o_pll_pd),
		.o_osc_raw(i_osc_raw), .o_pll_raw(i_pll_raw));
	always @(posedge i_clk) begin
		if (o_core_clk_en === 1'b1) core_n++;
		if (o_per_clk_en[7] === 1'b1) per_n++;
		if (o_per_clk_en[0] === 1'b1) div_n++;
		if (o_start_irq[0] === 1'b1) irq_n++;
	end
	always @(o_clock_output_pin) co_n++;
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	// ---------------------------------------------------------------
	// bus tasks and closing
	// ---------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_we <= 1'b1;
		@(posedge i_clk);
		i_we <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
		@(posedge i_clk);
		i_addr <= a;
		i_re <= 1'b1;
		@(posedge i_clk);
		i_re <= 1'b0;
		#1 `CHK(o_rdata, e)
	endtask
	task automatic complete_run();
		$display("fail_count=%0d cmp_count=%0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		cyc(1);
		`CHK(o_pll_pd, 1'b1)
		`CHK(o_pll_bypass, 1'b1)
		rd_chk(REG_MAIN_SEL, 32'h0);
		wr(REG_MAIN_SEL, 32'h3);
		rd_chk(REG_MAIN_SEL, 32'h0);
		wr(4'hf, 32'hffffffff);
		rd_chk(4'hf, 32'h0); // unmapped index
	endtask
	task automatic t_pll();
		for (int k = 0; k < 4; k++) begin
			wr(REG_PLL_CTRL, 32'h80 | (k << 5) | ((k & 1) << 8));
			cyc(1);
			`CHK(o_pll_post_div, 5'(2 << k))
			`CHK(o_pll_ref_sys, 1'(k & 1))
		end
		// 12 MHz times 32 over 16 stays under the output limit
		wr(REG_PLL_CTRL, 32'hff);
		cyc(1);
		`CHK(o_pll_msel, 5'h1f)
		`CHK(o_pll_pd, 1'b0)
		cyc(1990);
		`CHK(o_pll_bypass, 1'b1)
		cyc(15);
		`CHK(o_pll_bypass, 1'b0)
		rd_chk(REG_PLL_STAT, 32'h1);
		wr(REG_MAIN_SEL, 32'h3);
		cyc(40);
		rd_chk(REG_STATUS, 32'h6);
	endtask
	task automatic t_per();
		wr(REG_PER_EN, 32'h0);
		cyc(2);
		p = per_n;
		cyc(40);
		`CHK(per_n == p, 1'b1)
		wr(REG_PER_EN, 32'h81);
		wr(REG_PER_DIV0, 32'h4);
		wr(REG_CORE_DIV, 32'h0);
		cyc(4);
		p = per_n;
		q = div_n;
		c = core_n;
		cyc(40);
		`CHK(per_n > p, 1'b1)
		// divided peripheral sees one tick per four main rises
		q = 4 * (div_n - q) - (per_n - p);
		`CHK(q inside {[-4:4]}, 1'b1)
		`CHK(core_n == c, 1'b1)
		wr(REG_CORE_DIV, 32'h1);
	endtask
	task automatic t_sleep();
		wr(REG_PMODE, 32'h1);
		cyc(4);
		c = core_n;
		p = per_n;
		cyc(30);
		`CHK(core_n == c, 1'b1)
		`CHK(per_n > p, 1'b1)
		@(posedge i_clk);
		i_irq_any <= 1'b1;
		@(posedge i_clk);
		i_irq_any <= 1'b0;
		cyc(4);
		c = core_n;
		cyc(30);
		`CHK(core_n > c, 1'b1)
		rd_chk(REG_PMODE, 32'h0);
	endtask
	task automatic t_deep();
		wr(REG_START_EN, 32'h1);
		c = irq_n;
		@(posedge i_clk);
		i_start_raw[0] <= 1'b1;
		cyc(8);
		`CHK(irq_n == c + 1, 1'b1)
		// watchdog kept, brownout not kept
		wr(REG_PMODE, 32'h6);
		cyc(2);
		`CHK(o_analog_off, 1'b1)
		`CHK(o_wdt_osc_run, 1'b1)
		`CHK(o_bod_run, 1'b0)
		@(posedge i_clk);
		i_start_raw[0] <= 1'b0;
		cyc(8);
		`CHK(o_analog_off, 1'b0)
		rd_chk(REG_PLL_STAT, 32'h0);
		rd_chk(REG_MAIN_SEL, 32'h0);
	endtask
	task automatic t_off();
		wr(REG_MAIN_SEL, 32'h1);
		wr(REG_PMODE, 32'h3);
		cyc(2);
		`CHK(o_power_off, 1'b1)
		// short glitch lands between sampling edges
		#10 i_exit_raw_b = 1'b0;
		#10 i_exit_raw_b = 1'b1;
		cyc(6);
		`CHK(o_power_off, 1'b1)
		@(posedge i_clk);
		i_exit_raw_b <= 1'b0;
		@(posedge i_clk);
		i_exit_raw_b <= 1'b1;
		cyc(6);
		`CHK(o_power_off, 1'b0)
		rd_chk(REG_MAIN_SEL, 32'h0);
	endtask
	task automatic t_out();
		// toggles per 60 cycles: rc 15, system 10, watchdog 4 or 5
		int lo [4] = '{14, 9, 4, 14};
		for (int s = 0; s < 4; s++) begin
			wr(REG_CLOCK_OUTPUT_PIN, 32'h100 | s);
			cyc(4);
			c = co_n;
			cyc(60);
			`CHK((co_n - c) inside {[lo[s]:lo[s] + 2]}, 1'b1)
		end
		wr(REG_WDT_OSC, 32'h1ff);
		cyc(1);
		`CHK(o_wdt_freq, 9'h1ff)
		wr(REG_MAIN_SEL, 32'h2);
		cyc(60);
		rd_chk(REG_STATUS, 32'h4);
	endtask
	initial begin
		#1000000;
		fail_count++;
		complete_run();
	end
	initial begin
		i_rst_b = 1'b0;
		i_ce = 1'b1;
		i_we = 1'b0;
		i_re = 1'b0;
		i_addr = 4'h0;
		i_wdata = 32'h0;
		i_start_raw = 13'h0;
		i_exit_raw_b = 1'b1;
		i_irq_any = 1'b0;
		repeat (3) @(posedge i_clk);
		i_rst_b <= 1'b1;
		t_reset();
		t_pll();
		t_per();
		t_sleep();
		t_deep();
		t_off();
		t_out();
		complete_run();
	end
endmodule
